// File: rtl/afc_flow_ctrl.sv
`default_nettype none
// What this block does
// R1: with transmitter disabled, no pause frames and no backpressure at all
// R2: high level in bits 23:16, 64-byte units, triggers flow control
// R3: full duplex: one pause frame per high crossing, with programmed pause time
// R4: half duplex: each matching frame past high level is jammed for set duration
// R5: low level bits 15:8; fill dropping below sends zero-time pause
// R6: zero-time pause only after a real threshold pause was sent
// R7: software keeps low level strictly below high level
// R8: duration bits 7:4 set jam length, unused in full duplex
// R9: bit 3 jams multicast frames past threshold, half duplex only
// R10: bit 2 jams broadcast frames past threshold, half duplex only
// R11: bit 1 jams frames to own address past threshold, half duplex only
// R12: bit 0 acts on any frame and enables full duplex pause
// R13: half duplex any-frame acts on valid preamble, no address decode
// R14: full duplex any-frame requests pause from MAC at once
// R15: any-frame bit overrides bits 3:1
// R16: duration code table, 10 Mb/s adds 2.2 us
// R17: pause-issued flag set on threshold pause, cleared on resume or disable
module afc_flow_ctrl (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // register port
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    output logic [31:0] reg_rdata,
    // mac state
    input wire logic tx_enabled,
    input wire logic full_duplex,
    input wire logic speed_100,
    input wire logic [15:0] pause_time_value,
    // receive path
    input wire logic [13:0] rx_fifo_used,
    input wire logic rx_preamble,
    input wire logic rx_addr_valid,
    input wire logic rx_is_multicast,
    input wire logic rx_is_broadcast,
    input wire logic rx_is_own,
    // pause request to mac transmitter
    output logic pause_req,
    output logic [15:0] pause_time,
    input wire logic pause_ack,
    // half duplex backpressure
    output logic jam
);
    import afc_pkg::*;

    // ----------------------------------------
    // configuration register
    // ----------------------------------------
    logic [31:0] cfg_q;
    logic cfg_sel;
    assign cfg_sel = (reg_addr == AUTO_FLOW_CONFIG_OFFSET);

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            cfg_q <= AUTO_FLOW_CONFIG_RESET;
        end else if (reg_wr && cfg_sel) begin
            cfg_q <= reg_wdata & CFG_WMASK;
        end
    end

    // ----------------------------------------
    // register read port
    // ----------------------------------------
    // bits 31:24 read back as zero through the write mask
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            reg_rdata <= '0;
        end else if (reg_rd && cfg_sel) begin
            reg_rdata <= cfg_q;
        end else if (reg_rd) begin
            reg_rdata <= '0;
        end
    end

    // ----------------------------------------
    // configuration fields
    // ----------------------------------------
    logic [7:0] flow_high_level;
    logic [7:0] flow_low_level;
    logic [3:0] jam_duration;
    logic throttle_on_multicast;
    logic throttle_on_broadcast;
    logic throttle_on_own_address;
    logic throttle_on_any_frame;
    assign flow_high_level = cfg_q[HI_MSB:HI_LSB];
    assign flow_low_level = cfg_q[LO_MSB:LO_LSB];
    assign jam_duration = cfg_q[DUR_MSB:DUR_LSB];
    assign throttle_on_multicast = cfg_q[BIT_MULT];
    assign throttle_on_broadcast = cfg_q[BIT_BRD];
    assign throttle_on_own_address = cfg_q[BIT_OWN];
    assign throttle_on_any_frame = cfg_q[BIT_ANY];

    // ----------------------------------------
    // fill level compare
    // ----------------------------------------
    // compare in 64-byte units; partial granules round down
    logic [7:0] fill_units;
    logic above_high;
    logic below_low;
    logic auto_on;
    assign fill_units = 8'(rx_fifo_used >> UNIT_SHIFT);
    // a zero high level would fire on an empty fifo; treated as disabled
    assign above_high = (flow_high_level != 8'h00) && (fill_units >= flow_high_level); // R2
    assign below_low = fill_units < flow_low_level; // R5
    // low must sit below high, otherwise resume and trigger race
    assign auto_on = (cfg_q[3:0] != 4'h0) && tx_enabled; // R7

    // ----------------------------------------
    // full duplex pause sequencing
    // ----------------------------------------
    typedef enum logic [2:0] {
        AFC_IDLE = 3'b001,
        AFC_PAUSED = 3'b010,
        AFC_RESUME = 3'b100
    } afc_state_t;

    afc_state_t st_q;
    logic pause_issued_q;
    // armed_q blocks a second threshold pause until the resume is acked
    logic armed_q;
    logic fd_on;
    // pause logic only runs in full duplex with bit 0 and a live transmitter
    assign fd_on = tx_enabled && full_duplex && throttle_on_any_frame;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            st_q <= AFC_IDLE;
            pause_req <= 1'b0;
            pause_time <= 16'h0000;
            pause_issued_q <= 1'b0;
            armed_q <= 1'b1;
        end else if (!fd_on) begin
            st_q <= AFC_IDLE; // R1 R12
            pause_req <= 1'b0;
            pause_issued_q <= 1'b0; // R17
            armed_q <= 1'b1;
        end else begin
            case (st_q)
                AFC_IDLE: begin
                    if (pause_req && pause_ack) begin
                        pause_req <= 1'b0;
                        pause_issued_q <= 1'b1; // R17
                        st_q <= AFC_PAUSED;
                    end else if (!pause_req && above_high && armed_q) begin
                        pause_req <= 1'b1; // R14
                        pause_time <= pause_time_value; // R3
                        armed_q <= 1'b0; // R3
                    end
                end
                AFC_PAUSED: begin
                    if (below_low && pause_issued_q) begin
                        pause_req <= 1'b1; // R6
                        pause_time <= 16'h0000; // R5
                        st_q <= AFC_RESUME;
                    end
                end
                AFC_RESUME: begin
                    if (pause_ack) begin
                        pause_req <= 1'b0;
                        pause_issued_q <= 1'b0; // R17
                        armed_q <= 1'b1;
                        st_q <= AFC_IDLE;
                    end
                end
                default: begin
                    st_q <= AFC_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------
    // half duplex backpressure
    // ----------------------------------------
    logic hit_any;
    logic hit_sel;
    logic jam_start;
    logic jam_abort;
    logic jam_busy;
    assign hit_any = throttle_on_any_frame && rx_preamble; // R13
    // selection bits only matter without the any-frame bit
    assign hit_sel = !throttle_on_any_frame && rx_addr_valid && // R15
        ((throttle_on_multicast && rx_is_multicast) || // R9
         (throttle_on_broadcast && rx_is_broadcast) || // R10
         (throttle_on_own_address && rx_is_own)); // R11
    assign jam_start = auto_on && !full_duplex && above_high && (hit_any || hit_sel); // R4
    // duration is dropped as soon as duplex flips to full
    assign jam_abort = !tx_enabled || full_duplex; // R8 R1

    // ----------------------------------------
    // jam length timer
    // ----------------------------------------
    // a retrigger reloads the count, so the jam stretches
    afc_jam_timer u_jam_timer (
        .clk_sys(clk_sys),
        .rst(rst),
        .start(jam_start),
        .abort(jam_abort),
        .code(jam_duration),
        .speed_100(speed_100),
        .busy(jam_busy)
    );

    // ----------------------------------------
    // jam output
    // ----------------------------------------
    // abort also drops the output flop, one cycle after the cause

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            jam <= 1'b0;
        end else begin
            jam <= jam_busy && !jam_abort; // R1 R4
        end
    end
endmodule
`default_nettype wire

// File: shared/afc_pkg.sv
`default_nettype none
package afc_pkg;
    // ----------------------------------------
    // register map
    // ----------------------------------------
    localparam logic [7:0] AUTO_FLOW_CONFIG_OFFSET = 8'hAC;
    localparam logic [31:0] AUTO_FLOW_CONFIG_RESET = 32'h0000_0000;
    localparam int HI_MSB = 23;
    localparam int HI_LSB = 16;
    localparam int LO_MSB = 15;
    localparam int LO_LSB = 8;
    localparam int DUR_MSB = 7;
    localparam int DUR_LSB = 4;
    localparam int BIT_MULT = 3;
    localparam int BIT_BRD = 2;
    localparam int BIT_OWN = 1;
    localparam int BIT_ANY = 0;
    localparam logic [31:0] CFG_WMASK = 32'h00FF_FFFF;
    // fill level granule is 64 bytes
    localparam int UNIT_SHIFT = 6;
    // ----------------------------------------
    // timing
    // ----------------------------------------
    localparam int CLK_MHZ = 25;
    // jam duration table in tenths of a microsecond, 100 Mb/s
    localparam int DUR_STEP_TENTHS = 500;
    localparam int DUR_C0_TENTHS = 50;
    localparam int DUR_C1_TENTHS = 100;
    localparam int DUR_C2_TENTHS = 150;
    localparam int DUR_C3_TENTHS = 250;
    localparam int SLOW_EXTRA_TENTHS = 22;
    // cycles = tenths * CLK_MHZ / 10, rounded up
    localparam int DUR_CYC_W = 16;
    function automatic logic [DUR_CYC_W-1:0] dur_cycles(input logic [3:0] code,
                                                        input logic speed_100);
        int t;
        case (code)
            4'h0: t = DUR_C0_TENTHS;
            4'h1: t = DUR_C1_TENTHS;
            4'h2: t = DUR_C2_TENTHS;
            4'h3: t = DUR_C3_TENTHS;
            default: t = DUR_STEP_TENTHS * (int'(code) - 3);
        endcase
        if (!speed_100) begin
            t = t + SLOW_EXTRA_TENTHS;
        end
        return DUR_CYC_W'((t * CLK_MHZ + 9) / 10);
    endfunction
endpackage
`default_nettype wire

// File: rtl/afc_jam_timer.sv
`default_nettype none
// ----------------------------------------
// jam length timer
// ----------------------------------------
module afc_jam_timer (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // control
    input wire logic start,
    input wire logic abort,
    input wire logic [3:0] code,
    input wire logic speed_100,
    // status
    output logic busy
);
    import afc_pkg::*;
    logic [DUR_CYC_W-1:0] cnt_q;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            cnt_q <= '0;
        end else if (abort) begin
            cnt_q <= '0;
        end else if (start) begin
            cnt_q <= dur_cycles(code, speed_100); // R16
        end else if (cnt_q != '0) begin
            cnt_q <= cnt_q - DUR_CYC_W'(1);
        end
    end

    assign busy = (cnt_q != '0);
endmodule
`default_nettype wire

// File: test/afc_flow_ctrl_properties.sv
`default_nettype none
// ----
// flow control checks
// ----
module afc_flow_ctrl_properties (
    // watched ports
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic reg_wr,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic tx_enabled,
    input wire logic full_duplex,
    input wire logic [13:0] rx_fifo_used,
    input wire logic rx_preamble,
    input wire logic pause_req,
    input wire logic [15:0] pause_time,
    input wire logic pause_ack,
    input wire logic jam
);
    import afc_pkg::*;
    logic [31:0] cfg_q;
    logic [7:0] units;
    logic hd, hit;
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            cfg_q <= 32'h0;
        end else if (reg_wr && reg_addr == AUTO_FLOW_CONFIG_OFFSET) begin
            cfg_q <= reg_wdata;
        end
    end
    assign units = rx_fifo_used[13:6];
    assign hd = tx_enabled && !full_duplex;
    // level zero never counts as reached
    assign hit = cfg_q[23:16] != 8'h0 && units >= cfg_q[23:16];
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    sequence quiet_s; !pause_req && !jam; endsequence
    sequence zero_s; pause_req && pause_time == 16'h0; endsequence
    tx_off_a: assert property (!tx_enabled [*2] |-> quiet_s) else $error("tx off");
    fd_jam_a: assert property (full_duplex [*2] |-> !jam) else $error("fd jam");
    pre_jam_a: assert property (hd && hit && cfg_q[0] && rx_preamble ##1 hd [*2] |-> jam)
        else $error("no jam");
    any_ovr_a: assert property (hd && cfg_q[0] && !rx_preamble ##1 !jam && !rx_preamble
        |=> !jam) else $error("jam w/o preamble");
    req_cause_a: assert property ($rose(pause_req) && pause_time != 16'h0
        |-> $past(hit) && full_duplex && cfg_q[0]) else $error("bad pause");
    req_hold_a: assert property (pause_req && !pause_ack && full_duplex && tx_enabled &&
        !reg_wr && !$past(reg_wr) |=> pause_req && $stable(pause_time)) else $error("req");
    ack_drop_a: assert property (pause_req && pause_ack |=> !pause_req) else $error("ack");
    zero_low_a: assert property ($rose(pause_req) ##0 zero_s |-> $past(units) < cfg_q[15:8])
        else $error("zero pause");
endmodule
bind afc_flow_ctrl afc_flow_ctrl_properties u_props (.clk_sys, .rst, .reg_wr, .reg_addr,
    .reg_wdata, .tx_enabled, .full_duplex, .rx_fifo_used, .rx_preamble, .pause_req,
    .pause_time, .pause_ack, .jam);
`default_nettype wire

// File: test/afc_link_partner.sv
`default_nettype none
// ----
// remote station and mac side
// ----
module afc_link_partner (
    // bench control
    input wire logic clk_sys,
    input wire logic send,
    input wire logic [2:0] kind,
    input wire logic [3:0] ack_dly,
    // controller side
    input wire logic pause_req,
    output logic rx_preamble,
    output logic rx_addr_valid,
    output logic [2:0] flags,
    output logic pause_ack
);
    logic go_q = 1'b0;
    int w = 0;
    initial {rx_preamble, rx_addr_valid, flags, pause_ack} = 6'h0;
    always @(posedge clk_sys) go_q <= send;
    always @(negedge clk_sys) begin
        rx_preamble <= go_q;
        rx_addr_valid <= rx_preamble;
        // flags mean nothing off the decode strobe
        flags <= rx_preamble ? kind : ~flags;
        w = (pause_req && !pause_ack) ? w + 1 : 0;
        pause_ack <= w > ack_dly;
    end
endmodule
`default_nettype wire

// File: test/auto_flow_control_tb.sv
`default_nettype none
module auto_flow_control_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import afc_pkg::*;
    logic clk_sys = 0, rst = 1, reg_wr = 0, reg_rd = 0, tx_enabled = 0, full_duplex = 0;
    logic speed_100 = 1, send = 0, pre, av, pause_req, pause_ack, jam;
    logic [7:0] reg_addr = 8'h0;
    logic [31:0] reg_wdata = 32'h0, reg_rdata;
    logic [15:0] pause_time_value = 16'h1234, pause_time;
    logic [13:0] rx_fifo_used = 14'h0;
    logic [2:0] kind = 3'h0, fl;
    logic [3:0] ack_dly = 4'h0;
    int n_fail = 0, compares = 0, n;
    initial forever #20 clk_sys = ~clk_sys;
    afc_flow_ctrl u_dut (.clk_sys, .rst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
        .tx_enabled, .full_duplex, .speed_100, .pause_time_value, .rx_fifo_used,
        .rx_preamble(pre), .rx_addr_valid(av), .rx_is_multicast(fl[2]),
        .rx_is_broadcast(fl[1]), .rx_is_own(fl[0]), .pause_req, .pause_time, .pause_ack, .jam);
    afc_link_partner u_peer (.clk_sys, .send, .kind, .ack_dly, .pause_req, .rx_preamble(pre),
        .rx_addr_valid(av), .flags(fl), .pause_ack);
    task automatic chk(input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            n_fail++;
            $display("BAD t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask
    task automatic tick(input int k);
        repeat (k) @(negedge clk_sys);
    endtask
    task automatic wr(input logic [31:0] d);
        reg_addr = AUTO_FLOW_CONFIG_OFFSET;
        reg_wdata = d;
        reg_wr = 1;
        tick(1);
        reg_wr = 0;
        // idle cycle so a following write never re-raises the strobe in the same step
        tick(1);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        reg_addr = a;
        reg_rd = 1;
        tick(1);
        reg_rd = 0;
        chk(e, reg_rdata);
        tick(1);
    endtask
    // bounded wait, n returns cycles spent
    task automatic wait_sig(input bit on_jam, input logic v, input int lim);
        n = 0;
        while ((on_jam ? jam : pause_req) !== v && n < lim) begin
            tick(1);
            n++;
        end
        if ((on_jam ? jam : pause_req) !== v) begin
            chk(v, ~v);
            print_verdict();
        end
    endtask
    task automatic t_regs;
        rd(AUTO_FLOW_CONFIG_OFFSET, 32'h0);
        wr(32'hFFFF_FFFF);
        rd(AUTO_FLOW_CONFIG_OFFSET, 32'h00FF_FFFF);
        rd(8'hA8, 32'h0);
        wr(32'h0);
        $display("regs done");
    endtask
    task automatic t_fd;
        full_duplex = 1;
        tx_enabled = 1;
        wr(32'h0004_0201);
        rx_fifo_used = 14'd255;
        tick(10);
        chk(0, pause_req);
        rx_fifo_used = 14'd256;
        wait_sig(0, 1, 3);
        chk(pause_time_value, pause_time);
        wait_sig(0, 0, 9);
        tick(40);
        chk(0, pause_req);
        rx_fifo_used = 14'd128;
        tick(10);
        chk(0, pause_req);
        ack_dly = 4'h9;
        rx_fifo_used = 14'd127;
        wait_sig(0, 1, 3);
        chk(0, pause_time);
        wait_sig(0, 0, 20);
        rx_fifo_used = 14'd256;
        wait_sig(0, 1, 3);
        wait_sig(0, 0, 20);
        wr(32'h0);
        rx_fifo_used = 14'h0;
        wr(32'h0004_0201);
        tick(20);
        chk(0, pause_req);
        tx_enabled = 0;
        rx_fifo_used = 14'd1000;
        tick(20);
        chk(0, pause_req);
        $display("full duplex done");
    endtask
    task automatic t_jam;
        logic [7:0] lo8 [5] = '{8'h08, 8'h14, 8'h02, 8'h49, 8'h08};
        logic [2:0] kd [5] = '{3'h4, 3'h2, 3'h1, 3'h0, 3'h2};
        int len [5] = '{125, 250, 180, 1250, 0};
        full_duplex = 0;
        tx_enabled = 1;
        for (int i = 0; i < 5; i++) begin
            speed_100 = i != 2;
            wr({16'h0004, 8'h02, lo8[i]});
            kind = kd[i];
            send = 1;
            tick(1);
            send = 0;
            if (len[i] == 0) begin
                tick(10);
                chk(0, jam);
            end else begin
                wait_sig(1, 1, 6);
                wait_sig(1, 0, 1300);
                chk(len[i], n);
            end
        end
        $display("half duplex done");
    endtask
    task automatic print_verdict;
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    initial begin
        tick(20);
        rst = 0;
        tick(1);
        t_regs;
        t_fd;
        t_jam;
        print_verdict();
    end
endmodule
`default_nettype wire
